// >>> verilog/cvd_top.sv
// Behaviour
// - accept instruction only when bits 7..4 match
// - bits 5..4 compare with strapped unit number
// - 64-location vector block, eight per channel
// - channel number drives vector bits 5..3
// - standard variant: bit 2 gives request type
// - block base strapped in 64-location steps
// - four-channel standard uses upper 32 only
// - dma variant interrupts only end-of-block, bit2 one
// - dma fetch/restore uses bit 2 zero
// - dma variant four channels, bank 0-3 or 4-7
// - dma bank 0-3 lower half, 4-7 upper
// - two shared-block units act as one
// - nearest unit in chain wins, address irrelevant
// - higher requester preempts burst, lower waits
// - downstream units rank below our end-of-block
// - eight baud clocks per channel, independent select
// - lowest-numbered channel of the chosen request type served first
// - data service above end-of-block, re-evaluated
//
// The placing of the registers and register access over APB were chosen for this implementation.
module cvd_top #(
  parameter int CLK_HZ = 40_000_000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // strap headers
  input wire logic [cvd_pkg::CVD_STRAP_W-1:0] unit_number_strap_header,
  input wire logic [cvd_pkg::CVD_BAUD_STRAP_W-1:0] baud_select_strap_header,
  // i/o instruction from processor
  input wire logic io_instr_valid,
  input wire logic [15:0] io_instr_word,
  output logic io_unit_selected,
  // channel adapters
  input wire logic [cvd_pkg::CVD_NUM_CH-1:0] chan_data_req,
  input wire logic [cvd_pkg::CVD_NUM_CH-1:0] chan_eob_req,
  output logic [cvd_pkg::CVD_NUM_CH-1:0] chan_baud_tick,
  // interrupt chain
  input wire logic int_chain_in,
  input wire logic int_ack,
  output logic int_chain_out,
  output logic bus_int_req,
  output logic [cvd_pkg::CVD_VEC_W-1:0] vec_addr,
  output logic vec_valid,
  // dma chain
  input wire logic dma_chain_in,
  input wire logic dma_grant,
  input wire logic dma_char_done,
  input wire logic dma_burst_last,
  output logic dma_chain_out,
  output logic dma_bus_req,
  output logic dma_active,
  output logic [cvd_pkg::CVD_VEC_W-1:0] dma_fetch_addr,
  // interrupt to local cpu
  output logic irq
);
  import cvd_pkg::*;

  localparam int NSYNC = CVD_STRAP_W + CVD_BAUD_STRAP_W + 2 * CVD_NUM_CH;

  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [CVD_STRAP_W-1:0] strap;
  logic [CVD_BAUD_STRAP_W-1:0] baud_strap;
  logic [CVD_NUM_CH-1:0] data_s;
  logic [CVD_NUM_CH-1:0] eob_s;
  logic [2:0] ctrl_reg;
  logic [CVD_EV_W-1:0] status_reg;
  logic [CVD_EV_W-1:0] status_next;
  logic [CVD_EV_W-1:0] mask_reg;
  logic [CVD_EV_W-1:0] ev_set;
  logic [CVD_EV_W-1:0] ev_clr;
  logic apb_done;
  logic [1:0] unit_num;
  logic [CVD_BASE_W-1:0] base;
  logic bank_hi;
  logic en;
  logic is_dma;
  logic four_ch;
  logic [CVD_NUM_CH-1:0] present;
  logic [CVD_NUM_CH-1:0] data_cand;
  logic [CVD_NUM_CH-1:0] eob_cand;
  logic [CVD_NUM_CH-1:0] dma_cand;
  logic int_pending;
  logic [CVD_CH_W-1:0] int_ch;
  logic int_type;
  logic [CVD_CH_W-1:0] dma_ch;
  logic dma_pending;
  logic int_take;
  cvd_dma_state_t dma_state;
  logic [CVD_NUM_CH-1:0] rate_tick;
  logic [CVD_DIV_W-1:0] div_tab [CVD_NUM_CH];

  // lowest set bit wins
  function automatic logic [CVD_CH_W-1:0] lowest(input logic [CVD_NUM_CH-1:0] v);
    logic [CVD_CH_W-1:0] r;
    r = '0;
    for (int i = CVD_NUM_CH - 1; i >= 0; i--)
    begin
      if (v[i])
        r = CVD_CH_W'(i);
    end
    return r;
  endfunction

  // divisor at 16x oversampling from the clock rate
  function automatic logic [CVD_DIV_W-1:0] div_of(input int rate);
    return CVD_DIV_W'(CLK_HZ / (CVD_OVERSAMPLE * rate));
  endfunction

  // straps and adapter requests come from off-board, two flops each
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {unit_number_strap_header, baud_select_strap_header, chan_data_req,
                    chan_eob_req};
      sync2_reg <= sync1_reg;
    end
  end

  assign {strap, baud_strap, data_s, eob_s} = sync2_reg;
  assign unit_num = strap[1:0];
  assign base = strap[4:2];
  assign bank_hi = strap[CVD_STRAP_BANK];
  assign en = ctrl_reg[CVD_CTRL_EN];
  assign is_dma = ctrl_reg[CVD_CTRL_DMA];
  assign four_ch = ctrl_reg[CVD_CTRL_FOUR];

  // channels that this unit owns inside its 64-location block
  always_comb
  begin
    for (int i = 0; i < CVD_NUM_CH; i++)
    begin
      if (is_dma)
        present[i] = (i / 4 == int'(bank_hi));
      else if (four_ch)
        present[i] = (i >= 4);
      else
        present[i] = 1'b1;
    end
  end

  // dma variant turns data requests into fetch/restore, never interrupts
  assign data_cand = (is_dma ? '0 : data_s) & present;
  assign eob_cand = eob_s & present;
  assign dma_cand = (is_dma ? data_s : '0) & present;
  assign int_pending = en & ((|data_cand) | (|eob_cand));
  assign int_type = (|data_cand) ? CVD_TYPE_DATA : CVD_TYPE_EOB;
  assign int_ch = (|data_cand) ? lowest(data_cand) : lowest(eob_cand);
  assign dma_pending = en & (|dma_cand);
  assign dma_ch = lowest(dma_cand);
  assign int_take = int_ack & int_chain_in & int_pending;

  // unit decode: upper pair fixed, lower pair strapped
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      io_unit_selected <= 1'b0;
    else
      io_unit_selected <= en & io_instr_valid
        & (io_instr_word[CVD_UNIT_MSB:CVD_UNIT_LSB] == {CVD_UNIT_FIXED, unit_num});
  end

  // request and chain pass-through; a pending unit blocks all below it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_int_req <= 1'b0;
      int_chain_out <= 1'b0;
    end
    else
    begin
      bus_int_req <= int_pending;
      int_chain_out <= int_chain_in & ~int_pending;
    end
  end

  // vector capture at the acknowledge; selection is recomputed every
  // cycle so the next service sees whatever is pending then
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      vec_addr <= '0;
      vec_valid <= 1'b0;
    end
    else
    begin
      vec_valid <= int_take;
      if (int_take)
        vec_addr <= {base, int_ch, int_type, 2'b00};
    end
  end

  // dma ownership: release after any character if the chain above
  // takes the grant back, otherwise hold lower units off until the end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dma_state <= CVD_DMA_IDLE;
      dma_fetch_addr <= '0;
    end
    else
    begin
      case (dma_state)
        CVD_DMA_IDLE:
        begin
          if (dma_pending)
            dma_state <= CVD_DMA_REQ;
        end
        CVD_DMA_REQ:
        begin
          if (!dma_pending)
            dma_state <= CVD_DMA_IDLE;
          else if (dma_grant && dma_chain_in)
          begin
            dma_state <= CVD_DMA_OWN;
            dma_fetch_addr <= {base, dma_ch, CVD_TYPE_DATA, 2'b00};
          end
        end
        CVD_DMA_OWN:
        begin
          if (dma_char_done && (dma_burst_last || !dma_chain_in))
            dma_state <= CVD_DMA_IDLE;
        end
        default:
          dma_state <= CVD_DMA_IDLE;
      endcase
    end
  end

  // dma outputs; chain out stays low while we want or hold the bus
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dma_bus_req <= 1'b0;
      dma_active <= 1'b0;
      dma_chain_out <= 1'b0;
    end
    else
    begin
      dma_bus_req <= (dma_state == CVD_DMA_REQ);
      dma_active <= (dma_state == CVD_DMA_OWN);
      dma_chain_out <= dma_chain_in & (dma_state == CVD_DMA_IDLE) & ~dma_pending;
    end
  end

  // seven fixed rates plus one strapped extra
  always_comb
  begin
    for (int i = 0; i < 7; i++)
      div_tab[i] = div_of(CVD_BAUD_FIXED[i]);
    case (baud_strap[CVD_BAUD_STRAP_W-1 -: 2])
      2'b01: div_tab[7] = div_of(CVD_BAUD_EXTRA[1]);
      2'b10: div_tab[7] = div_of(CVD_BAUD_EXTRA[2]);
      default: div_tab[7] = div_of(CVD_BAUD_EXTRA[0]);
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < CVD_NUM_CH; g++)
    begin : g_rate
      cvd_rate_tick u_rate (
        .sys_clk(sys_clk),
        .rst(rst),
        .divisor(div_tab[g]),
        .tick(rate_tick[g])
      );
    end
  endgenerate

  // per-channel pick of one of the eight rates
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      chan_baud_tick <= '0;
    else
      for (int i = 0; i < CVD_NUM_CH; i++)
        chan_baud_tick[i] <= rate_tick[baud_strap[i*CVD_BAUD_SEL_W +: CVD_BAUD_SEL_W]];
  end

  // apb: one wait state, answer registered
  assign apb_done = psel & penable & pready;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && penable && !pready)
      begin
        if (paddr == CVD_ADDR_CTRL)
          prdata <= {29'h0, ctrl_reg};
        else if (paddr == CVD_ADDR_STATUS)
          prdata <= {28'h0, status_reg};
        else if (paddr == CVD_ADDR_MASK)
          prdata <= {28'h0, mask_reg};
        else if (paddr == CVD_ADDR_VECTOR)
          prdata <= {7'h0, dma_fetch_addr, 7'h0, vec_addr};
        else if (paddr == CVD_ADDR_STRAP)
          prdata <= {6'h0, baud_strap};
        else
          pslverr <= 1'b1;
      end
    end
  end

  // writable registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= CVD_CTRL_RESET;
      mask_reg <= CVD_MASK_RESET;
    end
    else if (apb_done && pwrite)
    begin
      if (paddr == CVD_ADDR_CTRL)
        ctrl_reg <= pwdata[2:0];
      else if (paddr == CVD_ADDR_MASK)
        mask_reg <= pwdata[CVD_EV_W-1:0];
    end
  end

  // sticky events; a read clears only what it returned, and a new set wins
  assign ev_set[CVD_EV_INT] = int_take;
  assign ev_set[CVD_EV_BURST] = (dma_state == CVD_DMA_OWN) & dma_char_done & dma_burst_last;
  assign ev_set[CVD_EV_PREEMPT] = (dma_state == CVD_DMA_OWN) & dma_char_done
    & ~dma_burst_last & ~dma_chain_in;
  assign ev_set[CVD_EV_SELECT] = io_unit_selected;
  assign ev_clr = (apb_done && !pwrite && paddr == CVD_ADDR_STATUS)
    ? prdata[CVD_EV_W-1:0] : '0;
  assign status_next = (status_reg & ~ev_clr) | ev_set;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  // level interrupt
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(status_next & mask_reg);
  end

  property p_unit_match;
    @(posedge sys_clk) disable iff (rst)
    (en && io_instr_valid && io_instr_word[7:4] == {2'b11, unit_num}) |=> io_unit_selected;
  endproperty
  a_unit_match: assert property (p_unit_match)
    else $error("matching instruction not accepted");

  property p_unit_fixed;
    @(posedge sys_clk) disable iff (rst)
    (io_instr_word[7:6] != 2'b11) |=> !io_unit_selected;
  endproperty
  a_unit_fixed: assert property (p_unit_fixed)
    else $error("unit selected without fixed ones");

  property p_vec_form;
    @(posedge sys_clk) disable iff (rst)
    int_take |=> vec_valid && vec_addr[1:0] == 2'b00 && vec_addr[8:6] == $past(base)
      && vec_addr[5:3] == $past(int_ch);
  endproperty
  a_vec_form: assert property (p_vec_form)
    else $error("vector address badly formed");

  property p_dma_eob;
    @(posedge sys_clk) disable iff (rst)
    (vec_valid && $past(is_dma)) |-> vec_addr[2] && vec_addr[5] == $past(bank_hi);
  endproperty
  a_dma_eob: assert property (p_dma_eob)
    else $error("dma vector not end-of-block in own half");

  property p_four_upper;
    @(posedge sys_clk) disable iff (rst)
    (vec_valid && $past(!is_dma && four_ch)) |-> vec_addr[5];
  endproperty
  a_four_upper: assert property (p_four_upper)
    else $error("four-channel unit used lower half");

  property p_data_first;
    @(posedge sys_clk) disable iff (rst)
    (int_take && |data_cand) ##1 vec_valid |-> !vec_addr[2];
  endproperty
  a_data_first: assert property (p_data_first)
    else $error("end-of-block served over data request");

  property p_fetch_zero;
    @(posedge sys_clk) disable iff (rst)
    $rose(dma_active) |-> !dma_fetch_addr[2] && dma_fetch_addr[1:0] == 2'b00;
  endproperty
  a_fetch_zero: assert property (p_fetch_zero)
    else $error("fetch address bit 2 not zero");

  property p_chain_block;
    @(posedge sys_clk) disable iff (rst)
    int_pending |=> !int_chain_out;
  endproperty
  a_chain_block: assert property (p_chain_block)
    else $error("interrupt chain passed while pending");

  property p_burst_hold;
    @(posedge sys_clk) disable iff (rst)
    (dma_state == CVD_DMA_OWN && !dma_char_done) |=> !dma_chain_out ##1 dma_active;
  endproperty
  a_burst_hold: assert property (p_burst_hold)
    else $error("lower requester let in during burst");

  property p_irq_level;
    @(posedge sys_clk) disable iff (rst)
    (|(status_reg & mask_reg)) |-> irq || $past(ev_clr != '0);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("unmasked status without interrupt");

endmodule

// >>> verilog/cvd_pkg.sv
package cvd_pkg;

  // instruction word decode: unit address sits in bits 7..4
  localparam int CVD_UNIT_LSB = 4;
  localparam int CVD_UNIT_MSB = 7;
  localparam logic [1:0] CVD_UNIT_FIXED = 2'b11;

  // vector address layout: base 8..6, channel 5..3, type 2, zero 1..0
  localparam int CVD_VEC_W = 9;
  localparam int CVD_NUM_CH = 8;
  localparam int CVD_CH_W = 3;
  localparam int CVD_BASE_W = 3;
  localparam logic CVD_TYPE_DATA = 1'b0;
  localparam logic CVD_TYPE_EOB = 1'b1;

  // strap header layout: unit number 1..0, block base 4..2, dma bank 5
  localparam int CVD_STRAP_W = 6;
  localparam int CVD_STRAP_BANK = 5;

  // baud straps: three bits per channel, then two for the extra rate
  localparam int CVD_BAUD_SEL_W = 3;
  localparam int CVD_BAUD_STRAP_W = 26;
  localparam int CVD_OVERSAMPLE = 16;
  localparam int CVD_DIV_W = 16;
  localparam int CVD_BAUD_FIXED [0:6] = '{110, 150, 300, 1200, 2400, 4800, 9600};
  localparam int CVD_BAUD_EXTRA [0:2] = '{75, 600, 19200};

  // register map, byte addresses
  localparam logic [7:0] CVD_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CVD_ADDR_STATUS = 8'h04;
  localparam logic [7:0] CVD_ADDR_MASK = 8'h08;
  localparam logic [7:0] CVD_ADDR_VECTOR = 8'h0C;
  localparam logic [7:0] CVD_ADDR_STRAP = 8'h10;

  // control bits
  localparam int CVD_CTRL_EN = 0;
  localparam int CVD_CTRL_DMA = 1;
  localparam int CVD_CTRL_FOUR = 2;
  localparam logic [2:0] CVD_CTRL_RESET = 3'h1;

  // status event bits
  localparam int CVD_EV_W = 4;
  localparam int CVD_EV_INT = 0;
  localparam int CVD_EV_BURST = 1;
  localparam int CVD_EV_PREEMPT = 2;
  localparam int CVD_EV_SELECT = 3;
  localparam logic [3:0] CVD_MASK_RESET = 4'h0;

  typedef enum logic [2:0] {
    CVD_DMA_IDLE = 3'b001,
    CVD_DMA_REQ = 3'b010,
    CVD_DMA_OWN = 3'b100
  } cvd_dma_state_t;

endpackage

// >>> verilog/cvd_rate_tick.sv
// one-cycle enable every divisor clocks
module cvd_rate_tick (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // divide ratio, zero or one gives a tick every clock
  input wire logic [cvd_pkg::CVD_DIV_W-1:0] divisor,
  // enable pulse
  output logic tick
);
  import cvd_pkg::*;

  logic [CVD_DIV_W-1:0] cnt_reg;

  // count down; reloading on the tick keeps the period exact
  // a count above the new ratio reloads at once, so a strap change
  // is not stuck behind a long count left from the old ratio
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end
    else if (cnt_reg == '0 || cnt_reg >= divisor)
    begin
      cnt_reg <= (divisor > 16'h0001) ? divisor - 16'h0001 : 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg - 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule

// >>> tb/cvd_proc_model.sv
// processor side of the shared i/o bus, driven on the rising edge
module cvd_proc_model (
  // clock
  input wire logic sys_clk,
  // instruction and acknowledge
  output logic io_instr_valid,
  output logic [15:0] io_instr_word,
  output logic int_ack,
  // priority chains, high while upstream passes priority down
  output logic int_chain_in,
  output logic dma_chain_in,
  // dma handshake
  output logic dma_grant,
  output logic dma_char_done,
  output logic dma_burst_last
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus, nothing upstream claims priority
  initial
  begin
    io_instr_valid = 1'b0;
    io_instr_word = 16'h0000;
    int_ack = 1'b0;
    int_chain_in = 1'b1;
    dma_chain_in = 1'b1;
    dma_grant = 1'b0;
    dma_char_done = 1'b0;
    dma_burst_last = 1'b0;
  end

  // one instruction word for one cycle; word then inverted so no stale match
  task issue(input logic [15:0] w);
    @(posedge sys_clk);
    io_instr_valid <= 1'b1;
    io_instr_word <= w;
    @(posedge sys_clk);
    io_instr_valid <= 1'b0;
    io_instr_word <= ~w;
  endtask

  // one-cycle acknowledge pulse
  task ack;
    @(posedge sys_clk);
    int_ack <= 1'b1;
    @(posedge sys_clk);
    int_ack <= 1'b0;
  endtask

  // one-cycle dma grant
  task grant;
    @(posedge sys_clk);
    dma_grant <= 1'b1;
    @(posedge sys_clk);
    dma_grant <= 1'b0;
  endtask

  // one character moved; chain low means a unit above takes the bus
  task char_xfer(input logic last, input logic chain);
    @(posedge sys_clk);
    dma_char_done <= 1'b1;
    dma_burst_last <= last;
    dma_chain_in <= chain;
    @(posedge sys_clk);
    dma_char_done <= 1'b0;
    dma_burst_last <= 1'b0;
    dma_chain_in <= 1'b1;
  endtask

  // upstream unit claims or frees the interrupt chain
  task set_chain(input logic c);
    @(posedge sys_clk);
    int_chain_in <= c;
  endtask
endmodule

// >>> tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import cvd_pkg::*;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic [7:0] dreq = 8'h00;
  logic [7:0] ereq = 8'h00;
  logic [7:0] tick;
  logic io_instr_valid, int_ack, int_chain_in, dma_chain_in, dma_grant;
  logic dma_char_done, dma_burst_last, io_unit_selected, int_chain_out;
  logic bus_int_req, vec_valid, dma_chain_out, dma_bus_req, dma_active, irq;
  logic [15:0] io_instr_word;
  logic [8:0] vec_addr, dma_fetch_addr;
  int err_count = 0;
  int tests_run = 0;
  int c [0:2];

  always #12.5 sys_clk = ~sys_clk;

  // unit 2, block base 5, dma bank 4..7; ch0 extra 19200, ch1 9600, rest 110
  cvd_top #(.CLK_HZ(1_600_000)) i_cvd_top (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .unit_number_strap_header(6'h36), .baud_select_strap_header(26'h200_0037),
    .io_instr_valid(io_instr_valid), .io_instr_word(io_instr_word),
    .io_unit_selected(io_unit_selected), .chan_data_req(dreq), .chan_eob_req(ereq),
    .chan_baud_tick(tick), .int_chain_in(int_chain_in), .int_ack(int_ack),
    .int_chain_out(int_chain_out), .bus_int_req(bus_int_req), .vec_addr(vec_addr),
    .vec_valid(vec_valid), .dma_chain_in(dma_chain_in), .dma_grant(dma_grant),
    .dma_char_done(dma_char_done), .dma_burst_last(dma_burst_last),
    .dma_chain_out(dma_chain_out), .dma_bus_req(dma_bus_req),
    .dma_active(dma_active), .dma_fetch_addr(dma_fetch_addr), .irq(irq));

  cvd_proc_model i_cvd_proc_model (.sys_clk(sys_clk),
    .io_instr_valid(io_instr_valid), .io_instr_word(io_instr_word),
    .int_ack(int_ack), .int_chain_in(int_chain_in), .dma_chain_in(dma_chain_in),
    .dma_grant(dma_grant), .dma_char_done(dma_char_done),
    .dma_burst_last(dma_burst_last));

  task wrap_up;
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // expected vector: base 5, channel, type, two zero bits
  function automatic logic [8:0] vec(input int ch, input logic t);
    return {3'd5, 3'(ch), t, 2'b00};
  endfunction

  // apb master; waits for pready, read data taken at that edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // adapter request levels, then time for sync and pending
  task req(input logic [7:0] d, input logic [7:0] e);
    @(posedge sys_clk);
    dreq <= d;
    ereq <= e;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task t_regs;
    apb(1'b0, CVD_ADDR_CTRL, 0);
    chk(rd, 32'h0000_0001);
    apb(1'b0, CVD_ADDR_MASK, 0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, CVD_ADDR_STRAP, 0);
    chk(rd, 32'h0200_0037);
    apb(1'b0, 8'h14, 0);
    chk(rd, 32'h0000_0000);
    chk(er, 1'b1);
  endtask

  // only upper nibble 4'hE answers: fixed 11 plus strapped unit 2
  task t_decode;
    apb(1'b1, CVD_ADDR_MASK, 32'h0000_0008);
    for (int i = 0; i < 16; i++)
    begin
      i_cvd_proc_model.issue({8'h00, 4'(i), 4'h0});
      #1;
      chk(io_unit_selected, i == 14);
    end
    chk(irq, 1'b1);
    apb(1'b0, CVD_ADDR_STATUS, 0);
    chk(rd[3], 1'b1);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(irq, 1'b0);
    apb(1'b1, CVD_ADDR_MASK, 0);
  endtask

  task t_std;
    req(8'h28, 8'h04);
    chk({bus_int_req, int_chain_out}, 2'b10);
    i_cvd_proc_model.ack();
    #1;
    chk({vec_valid, vec_addr}, {1'b1, vec(3, 0)});
    req(8'h20, 8'h04);
    i_cvd_proc_model.ack();
    #1;
    chk(vec_addr, vec(5, 0));
    req(8'h00, 8'h04);
    i_cvd_proc_model.ack();
    #1;
    chk(vec_addr, vec(2, 1));
    i_cvd_proc_model.set_chain(1'b0);
    i_cvd_proc_model.ack();
    #1;
    chk(vec_valid, 1'b0);
    i_cvd_proc_model.set_chain(1'b1);
    req(8'h00, 8'h00);
  endtask

  task t_four;
    apb(1'b1, CVD_ADDR_CTRL, 32'h0000_0005);
    req(8'h42, 8'h00);
    i_cvd_proc_model.ack();
    #1;
    chk(vec_addr, vec(6, 0));
    req(8'h02, 8'h00);
    chk(bus_int_req, 1'b0);
    req(8'h00, 8'h00);
  endtask

  task t_dma;
    apb(1'b1, CVD_ADDR_CTRL, 32'h0000_0003);
    req(8'h02, 8'h00);
    chk({dma_bus_req, bus_int_req}, 2'b00);
    req(8'h40, 8'h00);
    chk({dma_bus_req, dma_chain_out}, 2'b10);
    i_cvd_proc_model.grant();
    @(posedge sys_clk);
    #1;
    chk({dma_active, dma_fetch_addr}, {1'b1, vec(6, 0)});
    i_cvd_proc_model.char_xfer(1'b0, 1'b1);
    dreq <= 8'h00;
    #1;
    chk(dma_active, 1'b1);
    i_cvd_proc_model.char_xfer(1'b1, 1'b1);
    @(posedge sys_clk);
    #1;
    chk(dma_active, 1'b0);
    apb(1'b0, CVD_ADDR_STATUS, 0);
    chk(rd[1], 1'b1);
    req(8'h40, 8'h00);
    i_cvd_proc_model.grant();
    dreq <= 8'h00;
    i_cvd_proc_model.char_xfer(1'b0, 1'b0);
    @(posedge sys_clk);
    #1;
    chk(dma_active, 1'b0);
    apb(1'b0, CVD_ADDR_STATUS, 0);
    chk(rd[2], 1'b1);
    req(8'h00, 8'h42);
    i_cvd_proc_model.ack();
    #1;
    chk(vec_addr, vec(6, 1));
    apb(1'b0, CVD_ADDR_VECTOR, 0);
    chk(rd, {7'h00, vec(6, 0), 7'h00, vec(6, 1)});
    req(8'h00, 8'h02);
    chk(bus_int_req, 1'b0);
    req(8'h00, 8'h00);
  endtask

  // tick counts over 400 cycles at a 1.6 MHz scaled clock
  task t_baud;
    c = '{0, 0, 0};
    repeat (400)
    begin
      @(posedge sys_clk);
      #1;
      for (int k = 0; k < 3; k++)
        c[k] += int'(tick[k]);
    end
    chk(c[0] >= 70 && c[0] <= 90, 1'b1);
    chk(c[1] >= 34 && c[1] <= 46, 1'b1);
    chk(c[2] <= 1, 1'b1);
  endtask

  // bound on the whole run
  initial
  begin
    #(25 * 20_000);
    err_count++;
    wrap_up();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_regs();
    t_decode();
    t_std();
    t_four();
    t_dma();
    t_baud();
    wrap_up();
  end
endmodule
